// ---- logic/cdt_map.svh ----
// register map, reset values and timing constants of the clock-data transmitter
//
// Behaviour
// - idle: clock and data outputs both held high.
// - clock output is an active-low strobe, one low pulse marks each bit.
// - data output inverted: one drives low, zero drives high.
// - default bit period about 1 ms: three 330 us thirds, inactive, low, inactive.
// - phase durations replaceable from the format tag timing registers.
// - digit is 4 value bits LSB first plus odd-parity bit.
// - values 11 start, 13 separator, 15 stop; 10, 12, 14 unused.
// - format bit 7 zero selects magstripe framing, decimal content only.
// - magstripe translation bits 3-2 code 00 drops nibbles above 9.
// - code 01 replaces each nibble above 9 by one separator.
// - code 10 sends every nibble as two decimal digits 00 to 15.
// - code 11 sends above-9 nibble as separator then value minus ten.
// - magstripe frame starts with 16 zero bits.
// - then start sentinel, translated content, stop sentinel.
// - after stop: check digit, XOR of zeros, start sentinel, content.
// - magstripe frame ends with 16 zero bits.
// - format bit 7 one selects raw: nibbles 0 to 15 sent unchanged.
// - raw frames carry no zeros, sentinels or check digit.
// - LED inputs active low, high or open means off.
// - LED inputs steer LEDs only when external control is configured.
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

`define CDT_ADDR_W 8
`define CDT_OFS_CTRL 8'h00
`define CDT_OFS_STATUS 8'h04
`define CDT_OFS_FORMAT 8'h08
`define CDT_OFS_T_PRE 8'h0c
`define CDT_OFS_T_LOW 8'h10
`define CDT_OFS_T_POST 8'h14
`define CDT_OFS_LED_CFG 8'h18
`define CDT_OFS_DATA 8'h1c

`define CDT_CTRL_START 0
`define CDT_CTRL_CLEAR 1
`define CDT_FMT_RAW 7
`define CDT_FMT_XL_HI 3
`define CDT_FMT_XL_LO 2
`define CDT_LED_EXT 0
`define CDT_LED_RED 1
`define CDT_LED_GRN 2
`define CDT_STAT_COUNT_LO 8

`define CDT_FORMAT_RST 8'h00
`define CDT_LED_CFG_RST 3'h0

`define CDT_CLK_MHZ 50
`define CDT_PHASE_US 330
`define CDT_PHASE_CYC (`CDT_PHASE_US * `CDT_CLK_MHZ)
`define CDT_ZERO_RUN 16

`define CDT_DIG_START 4'hb
`define CDT_DIG_SEP 4'hd
`define CDT_DIG_STOP 4'hf
`define CDT_DIG_TEN 4'ha

`endif

// ---- logic/cdt_pkg.sv ----
// types of the clock-data transmitter
package cdt_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_LEAD = 3'b001,
    SEQ_START = 3'b010,
    SEQ_BODY = 3'b011,
    SEQ_STOP = 3'b100,
    SEQ_LRC = 3'b101,
    SEQ_TRAIL = 3'b110,
    SEQ_END = 3'b111
  } cdt_seq_e;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_LOAD = 3'b001,
    PH_PRE = 3'b010,
    PH_LOW = 3'b011,
    PH_POST = 3'b100
  } cdt_phase_e;

  typedef enum logic [1:0] {
    XL_DROP = 2'b00,
    XL_SEP = 2'b01,
    XL_TWO = 2'b10,
    XL_SEP_REM = 2'b11
  } cdt_xlate_e;

endpackage

// ---- logic/cdt_transmitter.sv ----
// clock-data frame transmitter with nibble buffer, register port and LED steering
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`include "cdt_map.svh"

module cdt_transmitter #(
  parameter int P_DEPTH = 32,
  parameter int P_TW = 16,
  parameter logic [15:0] P_PHASE_CYC = 16'(`CDT_PHASE_CYC)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [`CDT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // link pins
  output logic o_dc_clk,
  output logic o_dc_data,
  // led pins
  input wire logic i_led_red_n,
  input wire logic i_led_green_n,
  output logic o_led_red,
  output logic o_led_green
);

  localparam int P_CW = $clog2(P_DEPTH + 1);
  localparam logic [4:0] P_RUN = 5'(`CDT_ZERO_RUN);
  localparam logic [4:0] P_DIG = 5'h05;

  // odd parity digit, value bits lsb first, parity last
  function automatic logic [4:0] digit_bits(input logic [3:0] v);
    digit_bits = {~(^v), v};
  endfunction

  function automatic logic [P_TW-1:0] load_cnt(input logic [P_TW-1:0] t);
    load_cnt = (t == '0) ? '0 : t - P_TW'(1);
  endfunction

  // append decode, shared by the buffer and its count; refused while busy or full
  function automatic logic push_hit(input logic wr, input logic [`CDT_ADDR_W-1:0] a, input logic held,
                                    input logic [P_CW-1:0] n);
    push_hit = wr && (a == `CDT_OFS_DATA) && !held && (n != P_CW'(P_DEPTH));
  endfunction

  logic [3:0] mem_q [P_DEPTH];
  logic [P_CW-1:0] count_q;
  logic [P_CW-1:0] rd_ptr_q;
  logic [7:0] format_q;
  logic [P_TW-1:0] t_pre_q;
  logic [P_TW-1:0] t_low_q;
  logic [P_TW-1:0] t_post_q;
  logic [2:0] led_cfg_q;
  logic [P_TW-1:0] cnt_q;
  logic [4:0] shift_q;
  logic [4:0] left_q;
  logic [3:0] lrc_q;
  logic half_q;
  cdt_pkg::cdt_seq_e seq_q;
  cdt_pkg::cdt_phase_e ph_q;
  logic [1:0] red_sync_q;
  logic [1:0] grn_sync_q;

  logic busy;
  logic raw_mode;
  cdt_pkg::cdt_xlate_e xl_mode;
  logic wr_ctrl;
  logic start_req;
  logic cnt_done;
  logic [3:0] nib;
  logic big;

  assign busy = (ph_q != cdt_pkg::PH_IDLE);
  assign raw_mode = format_q[`CDT_FMT_RAW];
  assign xl_mode = cdt_pkg::cdt_xlate_e'(format_q[`CDT_FMT_XL_HI:`CDT_FMT_XL_LO]);
  assign wr_ctrl = i_wr && (i_addr == `CDT_OFS_CTRL);
  assign start_req = wr_ctrl && i_wdata[`CDT_CTRL_START] && !busy;
  assign cnt_done = (cnt_q == '0);
  // index wraps on a full buffer, but rd_ptr == count_q ends the body first
  assign nib = mem_q[rd_ptr_q[$clog2(P_DEPTH)-1:0]];
  assign big = (nib > 4'h9);

  // next symbol chosen in the load slot, while the clock sits high
  logic emit;
  logic emit_zeros;
  logic [3:0] emit_val;
  logic adv;
  logic half_d;
  logic lrc_acc;
  cdt_pkg::cdt_seq_e seq_d;

  always_comb begin
    emit = 1'b0;
    emit_zeros = 1'b0;
    emit_val = 4'h0;
    adv = 1'b0;
    half_d = half_q;
    lrc_acc = 1'b0;
    seq_d = seq_q;
    case (seq_q)
      cdt_pkg::SEQ_LEAD: begin
        emit = 1'b1;
        emit_zeros = 1'b1;
        seq_d = cdt_pkg::SEQ_START;
      end
      cdt_pkg::SEQ_START: begin
        emit = 1'b1;
        emit_val = `CDT_DIG_START;
        lrc_acc = 1'b1;
        seq_d = cdt_pkg::SEQ_BODY;
      end
      cdt_pkg::SEQ_BODY: begin
        if (rd_ptr_q == count_q) begin
          seq_d = raw_mode ? cdt_pkg::SEQ_END : cdt_pkg::SEQ_STOP;
        end else if (raw_mode) begin
          emit = 1'b1;
          emit_val = nib;
          adv = 1'b1;
        end else begin
          lrc_acc = 1'b1;
          case (xl_mode)
            cdt_pkg::XL_DROP: begin
              emit = !big;
              emit_val = nib;
              adv = 1'b1;
            end
            cdt_pkg::XL_SEP: begin
              emit = 1'b1;
              emit_val = big ? `CDT_DIG_SEP : nib;
              adv = 1'b1;
            end
            cdt_pkg::XL_TWO: begin
              emit = 1'b1;
              if (!half_q) begin
                emit_val = big ? 4'h1 : 4'h0;
                half_d = 1'b1;
              end else begin
                emit_val = big ? nib - `CDT_DIG_TEN : nib;
                half_d = 1'b0;
                adv = 1'b1;
              end
            end
            cdt_pkg::XL_SEP_REM: begin
              emit = 1'b1;
              if (big && !half_q) begin
                emit_val = `CDT_DIG_SEP;
                half_d = 1'b1;
              end else begin
                emit_val = big ? nib - `CDT_DIG_TEN : nib;
                half_d = 1'b0;
                adv = 1'b1;
              end
            end
            default: begin
              adv = 1'b1;
            end
          endcase
        end
      end
      cdt_pkg::SEQ_STOP: begin
        emit = 1'b1;
        emit_val = `CDT_DIG_STOP;
        seq_d = cdt_pkg::SEQ_LRC;
      end
      cdt_pkg::SEQ_LRC: begin
        emit = 1'b1;
        emit_val = lrc_q;
        seq_d = cdt_pkg::SEQ_TRAIL;
      end
      cdt_pkg::SEQ_TRAIL: begin
        emit = 1'b1;
        emit_zeros = 1'b1;
        seq_d = cdt_pkg::SEQ_END;
      end
      default: begin
        seq_d = cdt_pkg::SEQ_IDLE;
      end
    endcase
  end

  // nibble buffer; appends and clears are refused during a frame
  always_ff @(posedge i_clk) begin
    if (push_hit(i_wr, i_addr, busy, count_q)) begin
      mem_q[count_q[$clog2(P_DEPTH)-1:0]] <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_q <= '0;
    end else if (!busy && wr_ctrl && i_wdata[`CDT_CTRL_CLEAR]) begin
      count_q <= '0;
    end else if (push_hit(i_wr, i_addr, busy, count_q)) begin
      count_q <= count_q + P_CW'(1);
    end
  end

  // configuration registers
  // timing writes act at once, even inside a frame; no shadow copy is kept
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      format_q <= `CDT_FORMAT_RST;
      t_pre_q <= P_TW'(P_PHASE_CYC);
      t_low_q <= P_TW'(P_PHASE_CYC);
      t_post_q <= P_TW'(P_PHASE_CYC);
      led_cfg_q <= `CDT_LED_CFG_RST;
    end else if (i_wr) begin
      case (i_addr)
        `CDT_OFS_FORMAT: format_q <= i_wdata[7:0];
        `CDT_OFS_T_PRE: t_pre_q <= i_wdata[P_TW-1:0];
        `CDT_OFS_T_LOW: t_low_q <= i_wdata[P_TW-1:0];
        `CDT_OFS_T_POST: t_post_q <= i_wdata[P_TW-1:0];
        `CDT_OFS_LED_CFG: led_cfg_q <= i_wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      // status: buffer count from bit 8 upward, busy in bit 0
      case (i_addr)
        `CDT_OFS_STATUS: o_rdata <= 32'({count_q, 7'h00, busy});
        `CDT_OFS_FORMAT: o_rdata <= {24'h000000, format_q};
        `CDT_OFS_T_PRE: o_rdata <= 32'(t_pre_q);
        `CDT_OFS_T_LOW: o_rdata <= 32'(t_low_q);
        `CDT_OFS_T_POST: o_rdata <= 32'(t_post_q);
        `CDT_OFS_LED_CFG: o_rdata <= {29'h00000000, led_cfg_q};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // frame sequencer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      seq_q <= cdt_pkg::SEQ_IDLE;
      rd_ptr_q <= '0;
      half_q <= 1'b0;
      lrc_q <= 4'h0;
    end else if (start_req) begin
      seq_q <= raw_mode ? cdt_pkg::SEQ_BODY : cdt_pkg::SEQ_LEAD;
      rd_ptr_q <= '0;
      half_q <= 1'b0;
      lrc_q <= 4'h0; // leading zeros add nothing to the check
    end else if (ph_q == cdt_pkg::PH_LOAD) begin
      seq_q <= seq_d;
      half_q <= half_d;
      if (adv) begin
        rd_ptr_q <= rd_ptr_q + P_CW'(1);
      end
      // stop sentinel and check digit never fold into the check
      if (emit && lrc_acc) begin
        lrc_q <= lrc_q ^ emit_val;
      end
    end
  end

  // bit timing: load, inactive third, low third, inactive third
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ph_q <= cdt_pkg::PH_IDLE;
      cnt_q <= '0;
      shift_q <= 5'h00;
      left_q <= 5'h00;
    end else begin
      case (ph_q)
        cdt_pkg::PH_IDLE: begin
          shift_q <= 5'h00;
          if (start_req) begin
            ph_q <= cdt_pkg::PH_LOAD;
          end
        end
        cdt_pkg::PH_LOAD: begin
          // finished or empty raw frame returns to idle with no pulse;
          // a dropped nibble keeps the clock high one more load cycle
          if (seq_q == cdt_pkg::SEQ_END || seq_q == cdt_pkg::SEQ_IDLE) begin
            ph_q <= cdt_pkg::PH_IDLE;
            shift_q <= 5'h00;
          end else if (emit) begin
            shift_q <= emit_zeros ? 5'h00 : digit_bits(emit_val);
            left_q <= emit_zeros ? P_RUN : P_DIG;
            cnt_q <= load_cnt(t_pre_q);
            ph_q <= cdt_pkg::PH_PRE;
          end
        end
        cdt_pkg::PH_PRE: begin
          if (cnt_done) begin
            cnt_q <= load_cnt(t_low_q);
            ph_q <= cdt_pkg::PH_LOW;
          end else begin
            cnt_q <= cnt_q - P_TW'(1);
          end
        end
        cdt_pkg::PH_LOW: begin
          if (cnt_done) begin
            cnt_q <= load_cnt(t_post_q);
            ph_q <= cdt_pkg::PH_POST;
          end else begin
            cnt_q <= cnt_q - P_TW'(1);
          end
        end
        cdt_pkg::PH_POST: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - P_TW'(1);
          end else if (left_q > 5'h01) begin
            shift_q <= {1'b0, shift_q[4:1]};
            left_q <= left_q - 5'h01;
            cnt_q <= load_cnt(t_pre_q);
            ph_q <= cdt_pkg::PH_PRE;
          end else begin
            // last bit of the symbol: fetch the next one
            ph_q <= cdt_pkg::PH_LOAD;
          end
        end
        default: begin
          ph_q <= cdt_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // pins high when idle; clock low only in the middle third
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_dc_clk <= 1'b1;
    end else begin
      o_dc_clk <= !(ph_q == cdt_pkg::PH_LOW);
    end
  end

  // data registered like the clock, so both lag the phase equally
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_dc_data <= 1'b1;
    end else begin
      o_dc_data <= !(busy && shift_q[0]);
    end
  end

  // led inputs are asynchronous pins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      red_sync_q <= 2'b11;
      grn_sync_q <= 2'b11;
    end else begin
      red_sync_q <= {red_sync_q[0], i_led_red_n};
      grn_sync_q <= {grn_sync_q[0], i_led_green_n};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_led_red <= 1'b0;
      o_led_green <= 1'b0;
    end else if (led_cfg_q[`CDT_LED_EXT]) begin
      o_led_red <= !red_sync_q[1];
      o_led_green <= !grn_sync_q[1];
    end else begin
      o_led_red <= led_cfg_q[`CDT_LED_RED];
      o_led_green <= led_cfg_q[`CDT_LED_GRN];
    end
  end

endmodule // cdt_transmitter

// ---- sim/cdt_panel.sv ----
// listening model of the access panel on the clock-data link
`timescale 1ns/100ps

module cdt_panel (
  // clock and control
  input wire logic i_clk,
  input wire logic i_clr,
  // link
  input wire logic i_dc_clk,
  input wire logic i_dc_data,
  // captured bits
  output logic [127:0] o_bits,
  output logic [7:0] o_nbits
);
  logic clk_q;

  always_ff @(posedge i_clk) begin
    clk_q <= i_dc_clk;
    if (i_clr) begin
      o_bits <= 128'h0;
      o_nbits <= 8'h00;
    end else if (clk_q && !i_dc_clk) begin
      // only the falling edge counts, the rising edge is ignored
      o_bits[o_nbits[6:0]] <= !i_dc_data;
      o_nbits <= o_nbits + 8'h01;
    end
  end
endmodule // cdt_panel

// ---- sim/cdt_transmitter_monitor.sv ----
// port checker of the clock-data transmitter
`timescale 1ns/100ps
`include "cdt_map.svh"

module cdt_transmitter_monitor #(
  parameter logic [15:0] P_PHASE_CYC = 16'h0004
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // link and leds
  input wire logic o_dc_clk,
  input wire logic o_dc_data,
  input wire logic i_led_red_n,
  input wire logic o_led_red,
  input wire logic o_led_green
);
  logic [15:0] pre_q, low_q, hi_q, lo_q;
  logic ext_q, grn_q;

  // shadow of the writes the assertions depend on
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pre_q <= P_PHASE_CYC;
      low_q <= P_PHASE_CYC;
      ext_q <= 1'b0;
      grn_q <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        `CDT_OFS_T_PRE: pre_q <= i_wdata[15:0];
        `CDT_OFS_T_LOW: low_q <= i_wdata[15:0];
        `CDT_OFS_LED_CFG: begin
          ext_q <= i_wdata[0];
          grn_q <= i_wdata[2];
        end
        default: ;
      endcase
    end
  end

  // run lengths of the link clock levels
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      hi_q <= o_dc_clk ? ((hi_q == 16'hffff) ? hi_q : hi_q + 16'h0001) : 16'h0000;
      lo_q <= o_dc_clk ? 16'h0000 : lo_q + 16'h0001;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_idle_after_reset: assert property (!$past(i_resetn) |-> o_dc_clk && o_dc_data)
    else $error("link lines not high after reset");
  a_low_width: assert property ($rose(o_dc_clk) |-> lo_q == low_q)
    else $error("clock low phase has wrong length");
  a_pre_width: assert property ($fell(o_dc_clk) |-> hi_q >= pre_q)
    else $error("clock high phase too short");
  a_data_held_low: assert property (!o_dc_clk |-> $stable(o_dc_data))
    else $error("data moved while clock low");
  a_data_moves_high: assert property ($changed(o_dc_data) |-> o_dc_clk && $past(o_dc_clk))
    else $error("data moved next to a clock pulse");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_led_external: assert property (ext_q && $past(ext_q, 3) |-> o_led_red == !$past(i_led_red_n, 3))
    else $error("red led does not follow its pin");
  a_led_internal: assert property (!ext_q && !$past(ext_q) && $stable(grn_q) |-> o_led_green == grn_q)
    else $error("green led does not follow its setting");

  c_pulse: cover property ($rose(o_dc_clk));
  c_led_ext: cover property (ext_q && !i_led_red_n);
  c_read: cover property ($past(i_rd) && o_rdata != 32'h0);
endmodule // cdt_transmitter_monitor

bind cdt_transmitter cdt_transmitter_monitor #(.P_PHASE_CYC(P_PHASE_CYC)) u_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_dc_clk(o_dc_clk), .o_dc_data(o_dc_data),
  .i_led_red_n(i_led_red_n), .o_led_red(o_led_red), .o_led_green(o_led_green));

// ---- sim/cdt_transmitter_test.sv ----
// self-checking bench of the clock-data transmitter
`timescale 1ns/100ps
`include "cdt_map.svh"

module cdt_transmitter_test;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_led_red_n = 1'b1;
  logic i_led_green_n = 1'b1;
  logic clr = 1'b0;
  logic [31:0] o_rdata;
  logic o_dc_clk, o_dc_data, o_led_red, o_led_green;
  logic [127:0] bits;
  logic [7:0] nbits;
  logic [3:0] lrc;
  logic exp_q[$];
  int n_errors = 0;
  int total_checks = 0;

  always #10 i_clk = ~i_clk;

  cdt_transmitter #(.P_PHASE_CYC(16'h0004)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_dc_clk(o_dc_clk), .o_dc_data(o_dc_data),
    .i_led_red_n(i_led_red_n), .i_led_green_n(i_led_green_n),
    .o_led_red(o_led_red), .o_led_green(o_led_green));

  cdt_panel u_panel (.i_clk(i_clk), .i_clr(clr), .i_dc_clk(o_dc_clk), .i_dc_data(o_dc_data),
    .o_bits(bits), .o_nbits(nbits));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic dig(input logic [3:0] v);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(v[i]);
    end
    exp_q.push_back(~^v);
  endtask

  // content digit, also folded into the check digit
  task automatic cdig(input logic [3:0] v);
    dig(v);
    lrc = lrc ^ v;
  endtask

  task automatic run_frame(input logic [15:0] nib, input logic [7:0] fmt);
    logic [31:0] s;
    int k;
    wr(`CDT_OFS_CTRL, 32'h2);
    wr(`CDT_OFS_FORMAT, {24'h0, fmt});
    for (k = 0; k < 4; k++) begin
      wr(`CDT_OFS_DATA, {28'h0, nib[4*k +: 4]});
    end
    rd(`CDT_OFS_STATUS, s);
    chk("count", {26'h0, s[13:8]}, 32'h4);
    @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    wr(`CDT_OFS_CTRL, 32'h1);
    wr(`CDT_OFS_DATA, 32'h5);
    s = 32'h1;
    for (k = 0; k < 1500 && s[0]; k++) begin
      rd(`CDT_OFS_STATUS, s);
    end
    chk("busy end", {31'h0, s[0]}, 32'h0);
    if (s[0] !== 1'b0) begin
      stop_test();
    end
    chk("count kept", {26'h0, s[13:8]}, 32'h4);
    chk("clock idle", {31'h0, o_dc_clk}, 32'h1);
    chk("data idle", {31'h0, o_dc_data}, 32'h1);
    chk("bit count", {24'h0, nbits}, 32'(exp_q.size()));
    for (k = 0; k < exp_q.size(); k++) begin
      chk("bit", {31'h0, bits[k]}, {31'h0, exp_q[k]});
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd(`CDT_OFS_FORMAT, d);
    chk("format reset", d, 32'h0);
    rd(`CDT_OFS_T_PRE, d);
    chk("pre reset", d, 32'h4);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    rd(`CDT_OFS_DATA, d);
    chk("write only", d, 32'h0);
    wr(`CDT_OFS_T_PRE, 32'h3);
    wr(`CDT_OFS_T_LOW, 32'h2);
    wr(`CDT_OFS_T_POST, 32'h3);
    rd(`CDT_OFS_T_LOW, d);
    chk("low phase", d, 32'h2);
    rd(`CDT_OFS_T_POST, d);
    chk("post phase", d, 32'h3);
    $display("register test done");
  endtask

  task automatic t_raw();
    exp_q.delete();
    for (int k = 0; k < 4; k++) begin
      dig(4'(16'hfa50 >> (4*k)));
    end
    run_frame(16'hfa50, 8'h80);
    $display("raw test done");
  endtask

  task automatic t_mag();
    logic [3:0] v;
    for (int x = 0; x < 4; x++) begin
      exp_q.delete();
      lrc = `CDT_DIG_START;
      repeat (16) exp_q.push_back(1'b0);
      dig(`CDT_DIG_START);
      for (int k = 0; k < 4; k++) begin
        v = 4'(16'h2fa7 >> (4*k));
        case (x)
          0: if (v < 4'ha) cdig(v);
          1: cdig(v > 4'h9 ? `CDT_DIG_SEP : v);
          2: begin
            cdig({3'h0, v > 4'h9});
            cdig(v > 4'h9 ? v - 4'ha : v);
          end
          default: begin
            if (v > 4'h9) cdig(`CDT_DIG_SEP);
            cdig(v > 4'h9 ? v - 4'ha : v);
          end
        endcase
      end
      dig(`CDT_DIG_STOP);
      dig(lrc);
      repeat (16) exp_q.push_back(1'b0);
      run_frame(16'h2fa7, {4'h0, 2'(x), 2'b00});
    end
    $display("magstripe test done");
  endtask

  task automatic t_led();
    wr(`CDT_OFS_LED_CFG, 32'h1);
    i_led_red_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk("red on", {31'h0, o_led_red}, 32'h1);
    chk("green off", {31'h0, o_led_green}, 32'h0);
    i_led_red_n <= 1'b1;
    i_led_green_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk("red off", {31'h0, o_led_red}, 32'h0);
    chk("green on", {31'h0, o_led_green}, 32'h1);
    wr(`CDT_OFS_LED_CFG, 32'h4);
    i_led_red_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk("red cfg", {31'h0, o_led_red}, 32'h0);
    chk("green cfg", {31'h0, o_led_green}, 32'h1);
    $display("led test done");
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_raw();
    t_mag();
    t_led();
    stop_test();
  end
endmodule // cdt_transmitter_test
